//--- src/flash_bp_consts.svh
// constants for the status register and block-protection logic
`ifndef FLASH_BP_CONSTS_SVH
`define FLASH_BP_CONSTS_SVH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define CMD_WREN      8'h06
`define CMD_WRDI      8'h04
`define CMD_RDSR      8'h05
`define CMD_WRSR      8'h01
`define CMD_RDFSR     8'h70
`define CMD_CLRFSR    8'h50
`define CMD_PROG      8'h12
`define CMD_SECT_ERS  8'hDC
`define CMD_DIE_ERS   8'hC4

// ----------------------------------------------------------------
// status register field positions
// ----------------------------------------------------------------
`define SR_SRWD_BIT   7
`define SR_BPMSB_BIT  6
`define SR_TB_BIT     5
`define SR_BPLO_HI    4
`define SR_BPLO_LO    2
`define SR_WEL_BIT    1
`define SR_BUSY_BIT   0
`define SR_RESET      8'h00

// ----------------------------------------------------------------
// flag status register field positions
// ----------------------------------------------------------------
`define FSR_READY_BIT 7
`define FSR_ERS_BIT   5
`define FSR_PRG_BIT   4
`define FSR_PROT_BIT  1
`define FSR_ADDR_BIT  0

// ----------------------------------------------------------------
// array geometry and timing
// ----------------------------------------------------------------
`define ADDR_BITS     28
`define SECTOR_LSB    16
`define SECTOR_BITS   12
`define CLK_PERIOD_NS 5
`define WRSR_TIME_NS  1000
`define WRSR_CYCLES   ((`WRSR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

//--- src/flash_bp_pkg.sv
// types shared by the status register and block-protection logic
`default_nettype none
package flash_bp_pkg;
  typedef enum logic [3:0] {
    ST_OPC  = 4'b0001,
    ST_ADDR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_OUT  = 4'b1000
  } cmd_state_t;

  typedef enum logic [1:0] {
    OP_PROG  = 2'h0,
    OP_SECT  = 2'h1,
    OP_DIE   = 2'h2
  } op_kind_t;
endpackage
`default_nettype wire

//--- src/flash_status_block_protect.sv
// status register, block protection and command gating of a serial nor flash
//
// How it works
// - status bits 7 to 2 change only via write-status; read-status returns it
// - bit 7 set and write-protect pin low: write-status ignored
// - bit 7 arms pin protection; zero after reset allows writes
// - bit 5 picks top (0) or bottom (1) anchoring of region
// - protect code sits in bit 6 and bits 4 to 2
// - nonzero code refuses program and erase inside protected region
// - top: code n protects highest 2^(n-1) sectors; 13 up all
// - bottom: code n protects lowest 2^(n-1) sectors; 13 up all
// - die erase runs only when all protect bits are zero
// - write-enable latch clear at reset; needed for any modify
// - bit 0 reads busy during write-status, program or erase
// - bit 0 always inverse of flag bit 7
// - 28-bit address, sector index from address bits 27 to 16
// - program or erase on protected sector sets flag bit 1
// - flag bit 7 reads 0 busy, 1 ready
`include "flash_bp_consts.svh"
`default_nettype none
module flash_status_block_protect #(
  parameter int WRSR_CYCLES = `WRSR_CYCLES
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   sclk_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   si_i,
  input  wire logic                   wp_n_i,
  output var  logic                   so_o,
  output var  logic                   so_oe_o,
  output var  logic                   op_start_o,
  output var  flash_bp_pkg::op_kind_t op_kind_o,
  output var  logic [`ADDR_BITS-1:0]  op_addr_o,
  output var  logic [7:0]             op_data_o,
  input  wire logic                   op_done_i
);
  import flash_bp_pkg::*;

  // ----------------------------------------------------------------
  // front end and link
  // ----------------------------------------------------------------
  spi_link_if link ();

  logic so_q;
  logic so_oe_q;

  spi_frontend u_front (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .sclk_i    (sclk_i),
    .cs_n_i    (cs_n_i),
    .si_i      (si_i),
    .so_o      (so_q),
    .so_oe_o   (so_oe_q),
    .link      (link.front)
  );

  assign so_o    = so_q;
  assign so_oe_o = so_oe_q;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  cmd_state_t        state_q;
  logic [7:0]        cmd_q;
  logic [31:0]       addr_q;
  logic [1:0]        addr_cnt_q;
  logic [7:0]        data_q;
  logic              data_seen_q;
  logic              srwd_q;
  logic              tb_q;
  logic [3:0]        block_protect_code_q;
  logic              wel_q;
  logic              busy_q;
  logic              wrsr_active_q;
  logic              arr_active_q;
  logic [15:0]       wrsr_cnt_q;
  logic              err_prot_q;
  logic              err_prog_q;
  logic              err_erase_q;
  logic [1:0]        wp_s_q;
  logic              start_q;
  op_kind_t          kind_q;
  logic [`ADDR_BITS-1:0] op_addr_q;
  logic [7:0]        op_data_q;

  // write-protect pin crosses from outside; stage 0 feeds stage 1 only
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_s_q <= 2'h3;
    end else begin
      wp_s_q <= {wp_s_q[0], wp_n_i};
    end
  end

  // ----------------------------------------------------------------
  // command byte parser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= ST_OPC;
      cmd_q       <= 8'h00;
      addr_q      <= 32'h0000_0000;
      addr_cnt_q  <= 2'h0;
      data_q      <= 8'h00;
      data_seen_q <= 1'b0;
    end else if (link.frame_start) begin
      state_q     <= ST_OPC;
      data_seen_q <= 1'b0;
      addr_cnt_q  <= 2'h0;
    end else if (link.byte_valid) begin
      unique case (state_q)
        ST_OPC: begin
          cmd_q <= link.rx_byte;
          if (link.rx_byte == `CMD_PROG || link.rx_byte == `CMD_SECT_ERS) begin
            state_q <= ST_ADDR;
          end else if (link.rx_byte == `CMD_RDSR || link.rx_byte == `CMD_RDFSR) begin
            state_q <= ST_OUT;
          end else begin
            state_q <= ST_DATA;
          end
        end
        ST_ADDR: begin
          addr_q     <= {addr_q[23:0], link.rx_byte};
          addr_cnt_q <= addr_cnt_q + 2'h1;
          if (addr_cnt_q == 2'h3) begin
            state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          data_q      <= link.rx_byte; // program keeps the last byte sent
          data_seen_q <= 1'b1;
        end
        ST_OUT: begin
          data_seen_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register images and read path
  // ----------------------------------------------------------------
  logic [7:0] status_byte;
  logic [7:0] flag_byte;

  always_comb begin
    status_byte                             = `SR_RESET;
    status_byte[`SR_SRWD_BIT]               = srwd_q;
    status_byte[`SR_BPMSB_BIT]              = block_protect_code_q[3];
    status_byte[`SR_TB_BIT]                 = tb_q;
    status_byte[`SR_BPLO_HI:`SR_BPLO_LO]    = block_protect_code_q[2:0];
    status_byte[`SR_WEL_BIT]                = wel_q;
    status_byte[`SR_BUSY_BIT]               = busy_q;
    flag_byte                               = 8'h00;
    flag_byte[`FSR_READY_BIT]               = ~busy_q;
    flag_byte[`FSR_ERS_BIT]                 = err_erase_q;
    flag_byte[`FSR_PRG_BIT]                 = err_prog_q;
    flag_byte[`FSR_PROT_BIT]                = err_prot_q;
    flag_byte[`FSR_ADDR_BIT]                = 1'b1;                        // always 4-byte addressing
  end

  // live value each byte, so polling a busy bit sees it fall mid-frame
  assign link.tx_en   = (state_q == ST_OUT);
  assign link.tx_byte = (cmd_q == `CMD_RDSR) ? status_byte : flag_byte;

  // ----------------------------------------------------------------
  // execution decisions at frame end
  // ----------------------------------------------------------------
  logic sector_hit;
  logic exec_ok;
  logic wrsr_try;
  logic wrsr_locked;
  logic wrsr_go;
  logic wrsr_rej;
  logic prog_try;
  logic sect_try;
  logic die_try;
  logic arr_go;
  logic arr_rej;
  logic wrsr_done;
  logic arr_done;

  protect_decode #(
    .SECTOR_BITS (`SECTOR_BITS)
  ) u_decode (
    .code_i   (block_protect_code_q),
    .bottom_i (tb_q),
    .sector_i (addr_q[`ADDR_BITS-1:`SECTOR_LSB]),
    .hit_o    (sector_hit)
  );

  // modifying commands need the latch and an idle controller
  assign exec_ok     = link.frame_end & ~busy_q & wel_q;
  assign wrsr_try    = exec_ok & (cmd_q == `CMD_WRSR) & data_seen_q;
  assign wrsr_locked = srwd_q & ~wp_s_q[1];
  assign wrsr_go     = wrsr_try & ~wrsr_locked;
  assign wrsr_rej    = wrsr_try & wrsr_locked;
  assign prog_try    = exec_ok & (cmd_q == `CMD_PROG) & (state_q == ST_DATA) & data_seen_q;
  assign sect_try    = exec_ok & (cmd_q == `CMD_SECT_ERS) & (state_q == ST_DATA);
  assign die_try     = exec_ok & (cmd_q == `CMD_DIE_ERS) & (state_q == ST_DATA);
  assign arr_go      = ((prog_try | sect_try) & ~sector_hit) |
                       (die_try & (block_protect_code_q == 4'h0));
  assign arr_rej     = ((prog_try | sect_try) & sector_hit) |
                       (die_try & (block_protect_code_q != 4'h0));
  assign wrsr_done   = wrsr_active_q & (wrsr_cnt_q == 16'h0001);
  assign arr_done    = arr_active_q & op_done_i;

  // nonvolatile bits: loaded only by an unlocked write-status
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      srwd_q               <= 1'(`SR_RESET >> `SR_SRWD_BIT);
      tb_q                 <= 1'(`SR_RESET >> `SR_TB_BIT);
      block_protect_code_q <= 4'h0;
    end else if (wrsr_go) begin
      srwd_q               <= data_q[`SR_SRWD_BIT];
      tb_q                 <= data_q[`SR_TB_BIT];
      block_protect_code_q <= {data_q[`SR_BPMSB_BIT], data_q[`SR_BPLO_HI:`SR_BPLO_LO]};
    end
  end

  // write-enable latch; completion and rejection both drop it
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wel_q <= 1'b0;
    end else if (wrsr_rej | arr_rej | wrsr_done | arr_done) begin
      wel_q <= 1'b0;
    end else if (link.frame_end & ~busy_q & (cmd_q == `CMD_WRDI) & (state_q == ST_DATA)) begin
      wel_q <= 1'b0;
    end else if (link.frame_end & ~busy_q & (cmd_q == `CMD_WREN) & (state_q == ST_DATA)) begin
      wel_q <= 1'b1;
    end
  end

  // busy spans the write-status timer or the array operation
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_q        <= 1'b0;
      wrsr_active_q <= 1'b0;
      arr_active_q  <= 1'b0;
      wrsr_cnt_q    <= 16'h0000;
    end else begin
      if (wrsr_go) begin
        busy_q        <= 1'b1;
        wrsr_active_q <= 1'b1;
        wrsr_cnt_q    <= 16'(WRSR_CYCLES);
      end else if (arr_go) begin
        busy_q       <= 1'b1;
        arr_active_q <= 1'b1;
      end else if (wrsr_done | arr_done) begin
        busy_q        <= 1'b0;
        wrsr_active_q <= 1'b0;
        arr_active_q  <= 1'b0;
      end
      if (wrsr_active_q && wrsr_cnt_q != 16'h0000) begin
        wrsr_cnt_q <= wrsr_cnt_q - 16'h0001;
      end
    end
  end

  // error flags; a new error wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_prot_q  <= 1'b0;
      err_prog_q  <= 1'b0;
      err_erase_q <= 1'b0;
    end else if (arr_rej) begin
      err_prot_q  <= 1'b1;
      err_prog_q  <= err_prog_q | prog_try;
      err_erase_q <= err_erase_q | sect_try | die_try;
    end else if (link.frame_end & (cmd_q == `CMD_CLRFSR) & (state_q == ST_DATA)) begin
      err_prot_q  <= 1'b0;
      err_prog_q  <= 1'b0;
      err_erase_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // array request port
  // ----------------------------------------------------------------
  // refused requests never reach the array, so it is left unchanged
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_q   <= 1'b0;
      kind_q    <= OP_PROG;
      op_addr_q <= '0;
      op_data_q <= 8'h00;
    end else begin
      start_q <= arr_go;
      if (arr_go) begin
        kind_q    <= prog_try ? OP_PROG : (sect_try ? OP_SECT : OP_DIE);
        op_addr_q <= addr_q[`ADDR_BITS-1:0];
        op_data_q <= data_q;
      end
    end
  end

  assign op_start_o = start_q;
  assign op_kind_o  = kind_q;
  assign op_addr_o  = op_addr_q;
  assign op_data_o  = op_data_q;
endmodule // flash_status_block_protect
`default_nettype wire

//--- src/protect_decode.sv
// decodes the block-protect code and top/bottom bit against one sector index
`default_nettype none
module protect_decode #(
  parameter int SECTOR_BITS = 12
) (
  input  wire logic [3:0]             code_i,
  input  wire logic                   bottom_i,
  input  wire logic [SECTOR_BITS-1:0] sector_i,
  output var  logic                   hit_o
);
  logic [SECTOR_BITS-1:0] probe;
  logic [3:0]             shamt;

  // a region of 2^(n-1) sectors at the top holds every sector whose upper
  // bits are all ones; at the bottom, every sector whose upper bits are zero
  always_comb begin
    probe = bottom_i ? sector_i : ~sector_i;
    shamt = code_i - 4'h1;
    if (code_i == 4'h0) begin
      hit_o = 1'b0;
    end else if (code_i >= 4'hD) begin
      hit_o = 1'b1;
    end else begin
      hit_o = ((probe >> shamt) == '0);
    end
  end
endmodule // protect_decode
`default_nettype wire

//--- src/spi_frontend.sv
// oversampled serial front end: synchronisers, edge detect, byte shift in and out
`default_nettype none
module spi_frontend (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic sclk_i,
  input  wire logic cs_n_i,
  input  wire logic si_i,
  output var  logic so_o,
  output var  logic so_oe_o,
  spi_link_if.front link
);
  logic [2:0] sclk_s_q;
  logic       so_q;
  logic       so_oe_q;
  logic [2:0] cs_s_q;
  logic [1:0] si_s_q;
  logic [2:0] bit_cnt_q;
  logic [6:0] rx_sh_q;
  logic [7:0] tx_sh_q;
  logic       load_q;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       active;

  // ----------------------------------------------------------------
  // synchronisers; stage 0 is read only by stage 1
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_s_q <= 3'h0;
      cs_s_q   <= 3'h7;
      si_s_q   <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk_i};
      cs_s_q   <= {cs_s_q[1:0], cs_n_i};
      si_s_q   <= {si_s_q[0], si_i};
    end
  end

  assign active    = ~cs_s_q[1];
  assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2] & active;
  assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2] & active;

  // pins follow their flops directly, no logic in between
  assign so_o    = so_q;
  assign so_oe_o = so_oe_q;

  // frame edges as one-cycle pulses
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link.frame_start <= 1'b0;
      link.frame_end   <= 1'b0;
    end else begin
      link.frame_start <= cs_s_q[2] & ~cs_s_q[1];
      link.frame_end   <= ~cs_s_q[2] & cs_s_q[1];
    end
  end

  // shift in msb first on rising edges; count restarts every frame
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_q       <= 3'h0;
      rx_sh_q         <= 7'h00;
      link.byte_valid <= 1'b0;
      link.rx_byte    <= 8'h00;
    end else begin
      link.byte_valid <= 1'b0;
      if (!active) begin
        bit_cnt_q <= 3'h0;
      end else if (sclk_rise) begin
        rx_sh_q   <= {rx_sh_q[5:0], si_s_q[1]};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7) begin
          link.byte_valid <= 1'b1;
          link.rx_byte    <= {rx_sh_q, si_s_q[1]};
        end
      end
    end
  end

  // load one cycle after a byte so the core has settled its answer;
  // the next falling edge is many cycles away at any legal link rate
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_q  <= 1'b0;
      tx_sh_q <= 8'h00;
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      load_q  <= link.byte_valid;
      so_oe_q <= link.tx_en & active;
      if (load_q) begin
        tx_sh_q <= link.tx_byte;
      end else if (sclk_fall) begin
        so_q    <= tx_sh_q[7];
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end
endmodule // spi_frontend
`default_nettype wire

//--- src/spi_link_if.sv
// byte stream between the serial front end and the command core
`default_nettype none
interface spi_link_if;
  logic       byte_valid;
  logic [7:0] rx_byte;
  logic       frame_start;
  logic       frame_end;
  logic [7:0] tx_byte;
  logic       tx_en;

  modport front (output byte_valid, output rx_byte, output frame_start, output frame_end,
                 input tx_byte, input tx_en);
  modport core  (input byte_valid, input rx_byte, input frame_start, input frame_end,
                 output tx_byte, output tx_en);
endinterface
`default_nettype wire

//--- test/flash_bp_assertions.sv
// concurrent checks on the ports of the status and block-protect block
`default_nettype none
module flash_bp_assertions #(
  parameter int WRSR_CYCLES = 200
) (
  input wire logic                   ref_clk_i,
  input wire logic                   rst_i,
  input wire logic                   cs_n_i,
  input wire logic                   so_oe_o,
  input wire logic                   op_start_o,
  input wire flash_bp_pkg::op_kind_t op_kind_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import flash_bp_pkg::*;
  // ------
  // frame sequences
  // ------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence frame_close_s;
    $rose(cs_n_i);
  endsequence
  sequence idle_link_s;
    cs_n_i [*8];
  endsequence
  // ------
  // port relations
  // ------
  // reset itself is the cause here, so this one is never disabled
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |-> !op_start_o && !so_oe_o)
    else $error("output active during reset");
  start_pulse_a: assert property (op_start_o |=> !op_start_o)
    else $error("array start longer than one cycle");
  start_after_a: assert property (op_start_o |-> cs_n_i && $past(cs_n_i, 3))
    else $error("array start before the frame closed");
  kind_legal_a: assert property (op_start_o |-> op_kind_o inside {OP_PROG, OP_SECT, OP_DIE})
    else $error("array start with unknown kind");
  kind_hold_a: assert property (!op_start_o |-> $stable(op_kind_o))
    else $error("operation kind moved without a start");
  oe_in_frame_a: assert property ($rose(so_oe_o) |-> !cs_n_i)
    else $error("output enabled outside a frame");
  oe_release_a: assert property (frame_close_s |-> ##[1:6] !so_oe_o)
    else $error("output enable held after frame end");
  oe_idle_a: assert property (idle_link_s |-> !so_oe_o)
    else $error("output enabled on an idle link");
endmodule // flash_bp_assertions
`default_nettype wire

//--- test/flash_host_model.sv
// serial host model: mode 0 frames, msb first, last answer byte of each frame kept
`default_nettype none
module flash_host_model (
  input  wire logic ref_clk_i,
  input  wire logic so_i,
  input  wire logic so_oe_i,
  output var  logic sclk_o,
  output var  logic cs_n_o,
  output var  logic si_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam time HALF = 80ns;
  // idle: select high, clock parked low
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end
  // one frame of n bytes; rx keeps the last byte shifted in
  task automatic frame(input int n, input logic [7:0] tx [6], output logic [7:0] rx);
    @(posedge ref_clk_i);
    #1 cs_n_o = 1'b0;
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        si_o = tx[b][i];
        #HALF sclk_o = 1'b1;
        rx[i] = so_oe_i ? so_i : 1'bx; // undriven line never reads as data
        #HALF sclk_o = 1'b0;
      end
    end
    #HALF cs_n_o = 1'b1;
    si_o = ~si_o; // released data line must not look held
    #(2 * HALF);
  endtask
endmodule // flash_host_model
`default_nettype wire

//--- test/flash_status_block_protect_tb_top.sv
// self-checking bench: protection rows, then die erase, write enable, lock and reset cases
`include "flash_bp_consts.svh"
`default_nettype none
module flash_status_block_protect_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_bp_pkg::*;
  typedef struct packed {
    logic        bottom;
    logic [3:0]  code;
    logic [11:0] sec;
    logic        hit;
  } row_t;
  localparam int WRSR_CYCLES = 4;
  logic                  ref_clk_i = 1'b0;
  logic                  rst_i     = 1'b0;
  logic                  wp_n_i    = 1'b1;
  logic                  op_done_i = 1'b0;
  logic                  sclk_i, cs_n_i, si_i, so_o, so_oe_o, op_start_o;
  op_kind_t              op_kind_o, seen_kind;
  logic [`ADDR_BITS-1:0] op_addr_o, seen_addr;
  logic [7:0]            op_data_o, rx, sr;
  logic [7:0]            tx [6];
  int                    n_fail = 0, cmp_count = 0, starts = 0, s0 = 0, done_dly = 20, cnt = 0;
  // region boundaries: anchor, code, sector, refused
  row_t rows [12] = '{
    '{1'h0, 4'h0, 12'hFFF, 1'h0}, '{1'h0, 4'h1, 12'hFFF, 1'h1}, '{1'h0, 4'h1, 12'hFFE, 1'h0},
    '{1'h0, 4'hC, 12'h800, 1'h1}, '{1'h0, 4'hC, 12'h7FF, 1'h0}, '{1'h0, 4'hD, 12'h000, 1'h1},
    '{1'h1, 4'h1, 12'h000, 1'h1}, '{1'h1, 4'h1, 12'h001, 1'h0}, '{1'h1, 4'h7, 12'h03F, 1'h1},
    '{1'h1, 4'hC, 12'h7FF, 1'h1}, '{1'h1, 4'hC, 12'h800, 1'h0}, '{1'h1, 4'hF, 12'hFFF, 1'h1}};
  // ------
  // clock, design and far side
  // ------
  always #2.5 ref_clk_i = ~ref_clk_i;
  flash_status_block_protect #(.WRSR_CYCLES(WRSR_CYCLES)) flash_status_block_protect_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .si_i(si_i),
    .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o), .op_start_o(op_start_o), .op_kind_o(op_kind_o),
    .op_addr_o(op_addr_o), .op_data_o(op_data_o), .op_done_i(op_done_i));
  flash_host_model flash_host_model_i (.ref_clk_i(ref_clk_i), .so_i(so_o), .so_oe_i(so_oe_o),
    .sclk_o(sclk_i), .cs_n_o(cs_n_i), .si_o(si_i));
  // array model: records each start, ends it done_dly cycles later
  always @(posedge ref_clk_i) begin
    #1 op_done_i = 1'b0;
    if (cnt > 0) begin
      cnt--;
      op_done_i = (cnt == 0);
    end
    if (op_start_o === 1'b1) begin
      starts++;
      seen_kind = op_kind_o;
      seen_addr = op_addr_o;
      cnt = done_dly;
    end
  end
  // ------
  // helpers
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic send(input int n, input logic [7:0] b0, b1 = 8'h00, b2 = 8'h00, b3 = 8'h00, b4 = 8'h00,
                      b5 = 8'h00);
    tx = '{b0, b1, b2, b3, b4, b5};
    flash_host_model_i.frame(n, tx, rx);
  endtask
  // status polled until ready; rx then holds the settled status
  task automatic wait_ready;
    for (int k = 0; k < 40; k++) begin
      send(2, `CMD_RDSR);
      if (rx[0] === 1'b0) break;
    end
    check(rx[0], 1'b0);
  endtask
  task automatic wrsr(input logic [7:0] v);
    send(1, `CMD_WREN);
    send(2, `CMD_WRSR, v);
    wait_ready();
  endtask
  // address {sec, 1234h}; n of 6 adds one program data byte
  task automatic op_frame(input logic [7:0] op, input logic [11:0] sec, input int n);
    send(n, op, {4'h0, sec[11:8]}, sec[7:0], 8'h12, 8'h34, 8'h5A);
  endtask
  initial begin
    #500us;
    n_fail++;
    stop_test();
  end
  // ------
  // main sequence
  // ------
  initial begin
    // a real rising edge, so every flop is cleared before the first clock edge
    #1 rst_i = 1'b1;
    repeat (6) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    foreach (rows[r]) begin
      sr = {1'b0, rows[r].code[3], rows[r].bottom, rows[r].code[2:0], 2'b00};
      wrsr(sr);
      check(rx, sr);
      s0 = starts;
      send(1, `CMD_WREN);
      op_frame(`CMD_SECT_ERS, rows[r].sec, 5);
      check(starts - s0, !rows[r].hit);
      if (!rows[r].hit) check(seen_addr, {rows[r].sec, 16'h1234});
      wait_ready();
      check(rx, sr);
      send(2, `CMD_RDFSR);
      check(rx, rows[r].hit ? 8'hA3 : 8'h81);
      send(1, `CMD_CLRFSR);
    end
    // die erase refused under a nonzero code, then run while status is watched busy
    s0 = starts;
    send(1, `CMD_WREN);
    send(1, `CMD_DIE_ERS);
    check(starts - s0, 0);
    send(2, `CMD_RDFSR);
    check(rx, 8'hA3);
    send(1, `CMD_CLRFSR);
    // program into the fully protected array raises the program error too
    send(1, `CMD_WREN);
    op_frame(`CMD_PROG, 12'h100, 6);
    check(starts - s0, 0);
    send(2, `CMD_RDFSR);
    check(rx, 8'h93);
    send(1, `CMD_CLRFSR);
    wrsr(8'h00);
    done_dly = 1500;
    send(1, `CMD_WREN);
    send(1, `CMD_DIE_ERS);
    check(seen_kind, OP_DIE);
    send(2, `CMD_RDSR);
    check(rx, 8'h03);
    send(2, `CMD_RDFSR);
    check(rx, 8'h01);
    wait_ready();
    check(rx, 8'h00);
    done_dly = 20;
    // program needs the latch; without it no start reaches the array
    s0 = starts;
    op_frame(`CMD_PROG, 12'h100, 6);
    check(starts - s0, 0);
    // write-disable drops a freshly set latch
    send(1, `CMD_WREN);
    send(1, `CMD_WRDI);
    send(2, `CMD_RDSR);
    check(rx, 8'h00);
    send(1, `CMD_WREN);
    send(2, `CMD_RDSR);
    check(rx, 8'h02);
    op_frame(`CMD_PROG, 12'h100, 6);
    check(seen_kind, OP_PROG);
    check(op_data_o, 8'h5A);
    wait_ready();
    // pin lock: armed bit with the pin low freezes status until the pin goes high
    wrsr(8'h80);
    @(posedge ref_clk_i) #1 wp_n_i = 1'b0;
    wrsr(8'h00);
    check(rx, 8'h80);
    @(posedge ref_clk_i) #1 wp_n_i = 1'b1;
    wrsr(8'h00);
    check(rx, 8'h00);
    // reset in mid-run drops every stored bit
    wrsr(8'hFC);
    check(rx, 8'hFC);
    @(posedge ref_clk_i) #1 rst_i = 1'b1;
    repeat (6) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge ref_clk_i);
    send(2, `CMD_RDSR);
    check(rx, 8'h00);
    send(2, `CMD_RDFSR);
    check(rx, 8'h81);
    stop_test();
  end
endmodule // flash_status_block_protect_tb_top

bind flash_status_block_protect flash_bp_assertions #(.WRSR_CYCLES(WRSR_CYCLES)) flash_bp_assertions_i (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .so_oe_o(so_oe_o), .op_start_o(op_start_o),
  .op_kind_o(op_kind_o));
`default_nettype wire
